/* File: shared/bsc_defs.vh */
// Constants for the boot switch configuration decoder.
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH

// ==========================================================
// Status word layout and reset values.
`define BSC_STAT_W 16
`define BSC_STAT_POS_LSB 4
`define BSC_STAT_POS_MSB 7
`define BSC_STAT_RST 16'h0000
`define BSC_POS_RST 4'h0

// ==========================================================
// Switch position, low three bits, selects the startup response.
`define BSC_L3_APP 3'h0
`define BSC_L3_TEST_APP 3'h1
`define BSC_L3_CSUM_APP 3'h2
`define BSC_L3_TAPE 3'h3
`define BSC_L3_MONITOR 3'h4
`define BSC_L3_TEST_WAIT 3'h5
`define BSC_L3_WAIT 3'h6
`define BSC_L3_LOOP 3'h7
// Positions below this (low three bits) map the PROM low.
`define BSC_L3_PROM_HIGH 3'h3

// ==========================================================
// Bus size jumper codes (two jumpers, installed reads as 1).
`define BSC_SZ_16 2'h0
`define BSC_SZ_18 2'h1
`define BSC_SZ_22 2'h3

// ==========================================================
// Base address construction, 22-bit.
`define BSC_ADDR_W 22
`define BSC_BASE_LO 22'h3fe000
`define BSC_BASE_HI 22'h3ffa00
`define BSC_BASE_JOUT 22'h000400
`define BSC_BASE_STEP 22'h000020
`define BSC_ID_FIRST_ON 4'h2
// Low address bits that stay inside the board's register window.
`define BSC_WIN_LSB 5

// ==========================================================
// Checksum engine.
`define BSC_WORD_W 16
`define BSC_CK_RST 16'h0000

`endif

/* File: rtl/bsc_checksum.v */
// Rotate-and-add PROM checksum engine.
`timescale 1ns/1ns
`include "bsc_defs.vh"

module bsc_checksum (
  // Clock and reset.
  input wire i_clk,
  input wire i_rst_n,
  // Word stream.
  input wire i_start,
  input wire i_valid,
  input wire i_last,
  input wire [`BSC_WORD_W-1:0] i_word,
  // Result.
  output reg o_busy,
  output reg o_done,
  output reg o_ok,
  output reg [`BSC_WORD_W-1:0] o_sum
);

  // ==========================================================
  // Arithmetic.
  // Add with the carry dropped, then rotate left by one bit.
  function [`BSC_WORD_W-1:0] add_rotl;
    input [`BSC_WORD_W-1:0] acc;
    input [`BSC_WORD_W-1:0] word;
    reg [`BSC_WORD_W-1:0] s;
    begin
      s = acc + word;
      add_rotl = {s[`BSC_WORD_W-2:0], s[`BSC_WORD_W-1]};
    end
  endfunction

  // ==========================================================
  // Accumulator.
  // A start clears the sum; the last word holds the expected value.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_ok <= 1'b0;
      o_sum <= `BSC_CK_RST;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        // Fresh run, sum starts at zero.
        o_busy <= 1'b1;
        o_ok <= 1'b0;
        o_sum <= `BSC_CK_RST;
      end else if (o_busy && i_valid) begin
        if (i_last) begin
          // Highest word is the stored checksum, not summed.
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_ok <= (o_sum == i_word);
        end else begin
          o_sum <= add_rotl(o_sum, i_word);
        end
      end
    end
  end

endmodule // bsc_checksum

/* File: rtl/bsc_top.v */
// Boot switch configuration decoder with startup sequencer and base address decode.
`timescale 1ns/1ns
`include "bsc_defs.vh"

module bsc_top (
  // Clock and reset.
  input wire I_CLK,
  input wire I_RST_N,
  // Switches and jumpers (asynchronous pins).
  input wire [3:0] I_BOOT_SW,
  input wire I_FW_AT_POWERUP,
  input wire [1:0] I_BUS_SIZE_J,
  input wire I_BASE_JUMPER,
  input wire [3:0] I_ID_SW,
  // Host bus control and address pins.
  input wire I_BUS_HALT,
  input wire I_BUS_INIT,
  input wire [`BSC_ADDR_W-1:0] I_BUS_ADDR,
  input wire I_BUS_ADDR_VALID,
  // Selftest engine handshake (same clock).
  input wire I_SELFTEST_DONE,
  input wire I_SELFTEST_PASS,
  // Two-port command register write (same clock).
  input wire I_CMD_WR,
  input wire [`BSC_WORD_W-1:0] I_CMD_DATA,
  // PROM word stream for the checksum (same clock).
  input wire I_FW_CK_START,
  input wire I_CK_VALID,
  input wire I_CK_LAST,
  input wire [`BSC_WORD_W-1:0] I_CK_WORD,
  // Decoded configuration.
  output reg [`BSC_STAT_W-1:0] O_STATUS_B,
  output reg O_CFG_VALID,
  output reg O_SI_FIRMWARE,
  output reg O_SI_USER,
  output reg O_PROM_LOW,
  output reg O_BUS_ENABLE,
  output reg [1:0] O_BUS_SIZE,
  output reg [`BSC_ADDR_W-1:0] O_BASE_ADDR,
  output reg O_BUS_SELECT,
  // Startup sequence.
  output reg O_SELFTEST_RUN,
  output reg O_SELFTEST_FAIL,
  output reg O_CK_RUN,
  output reg O_CK_DONE,
  output reg O_CK_OK,
  output reg O_START_USER_APP,
  output reg O_TAPE_BOOT,
  output reg O_ENTER_MONITOR,
  output reg O_WAIT_COMMAND,
  output reg O_CMD_STROBE,
  output reg [`BSC_WORD_W-1:0] O_CMD_VALUE,
  output reg O_USER_SI_EVENT
);

  // ==========================================================
  // Sequencer states, one-hot.
  localparam [7:0] S_SAMPLE = 8'h01;
  localparam [7:0] S_TEST = 8'h02;
  localparam [7:0] S_CSUM = 8'h04;
  localparam [7:0] S_APP = 8'h08;
  localparam [7:0] S_TAPE = 8'h10;
  localparam [7:0] S_MON = 8'h20;
  localparam [7:0] S_WAIT = 8'h40;
  localparam [7:0] S_LOOP = 8'h80;

  // ==========================================================
  // Input synchronisers.
  // All pin levels go through two flops; the address is assumed
  // stable around its valid strobe, so skew between bits is harmless.
  reg [13:0] pin_s1; // First stage, read only by the second.
  reg [13:0] pin_s2; // Second stage, safe to use.
  reg [22:0] adr_s1; // First stage of address and valid.
  reg [22:0] adr_s2; // Second stage of address and valid.

  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pin_s1 <= 14'h0000;
      pin_s2 <= 14'h0000;
      adr_s1 <= 23'h000000;
      adr_s2 <= 23'h000000;
    end else begin
      pin_s1 <= {I_BOOT_SW, I_FW_AT_POWERUP, I_BUS_SIZE_J, I_BASE_JUMPER, I_ID_SW, I_BUS_HALT, I_BUS_INIT};
      pin_s2 <= pin_s1;
      adr_s1 <= {I_BUS_ADDR_VALID, I_BUS_ADDR};
      adr_s2 <= adr_s1;
    end
  end

  // Named views of the synchronised pins.
  wire [3:0] sw_pos = pin_s2[13:10];
  wire sw_fw = pin_s2[9];
  wire [1:0] sw_size = pin_s2[8:7];
  wire sw_jmp = pin_s2[6];
  wire [3:0] sw_id = pin_s2[5:2];
  wire si_level = pin_s2[1] | pin_s2[0];

  // ==========================================================
  // Configuration capture.
  // Settings are taken once after reset release, once the synchronisers
  // hold real pin values, and are frozen until the next reset.
  reg [1:0] settle; // Counts synchroniser fill cycles.
  reg [3:0] pos; // Captured boot switch position.
  reg fw_en; // Captured firmware-at-power-up jumper.
  wire settled = (settle == 2'h3);

  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      settle <= 2'h0;
      pos <= `BSC_POS_RST;
      fw_en <= 1'b0;
      O_CFG_VALID <= 1'b0;
      O_BUS_SIZE <= `BSC_SZ_16;
      O_BUS_ENABLE <= 1'b0;
      O_BASE_ADDR <= {`BSC_ADDR_W{1'b0}};
    end else if (!O_CFG_VALID) begin
      settle <= settle + 2'h1;
      if (settled) begin
        // One capture per reset.
        O_CFG_VALID <= 1'b1;
        pos <= sw_pos;
        fw_en <= sw_fw;
        O_BUS_SIZE <= sw_size;
        O_BUS_ENABLE <= (sw_id >= `BSC_ID_FIRST_ON);
        O_BASE_ADDR <= base_of(sw_id, sw_jmp);
      end
    end
  end

  // ==========================================================
  // Address helpers.
  // Base address from ID switch and jumper; positions 8 and up sit in
  // the upper block, the jumper removed adds a fixed offset.
  function [`BSC_ADDR_W-1:0] base_of;
    input [3:0] id;
    input jmp;
    reg [`BSC_ADDR_W-1:0] b;
    begin
      b = id[3] ? `BSC_BASE_HI : `BSC_BASE_LO;
      b = b + ({18'h00000, id} * `BSC_BASE_STEP);
      base_of = jmp ? b : (b + `BSC_BASE_JOUT);
    end
  endfunction

  // Compare mask for the selected address width.
  function [`BSC_ADDR_W-1:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `BSC_SZ_22: size_mask = 22'h3fffff;
        `BSC_SZ_18: size_mask = 22'h03ffff;
        default: size_mask = 22'h00ffff;
      endcase
    end
  endfunction

  // ==========================================================
  // Host bus select.
  // Only the low 16 or 18 bits count in narrow modes, and the window
  // bits below the base are ignored.
  wire [`BSC_ADDR_W-1:0] cmp_mask = size_mask(O_BUS_SIZE) & ~{{(`BSC_ADDR_W-`BSC_WIN_LSB){1'b0}}, 5'h1f};
  wire addr_hit = ((adr_s2[21:0] ^ O_BASE_ADDR) & cmp_mask) == {`BSC_ADDR_W{1'b0}};

  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_BUS_SELECT <= 1'b0;
    end else begin
      // A disabled interface never answers.
      O_BUS_SELECT <= O_BUS_ENABLE && adr_s2[22] && addr_hit;
    end
  end

  // ==========================================================
  // Position decode.
  wire [2:0] low3 = pos[2:0];
  wire si_none = (low3 == `BSC_L3_LOOP);
  wire pos_tests = (low3 == `BSC_L3_TEST_APP) || (low3 == `BSC_L3_CSUM_APP) || (low3 == `BSC_L3_TAPE) ||
                   (low3 == `BSC_L3_TEST_WAIT) || (low3 == `BSC_L3_LOOP);

  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_STATUS_B <= `BSC_STAT_RST;
      O_SI_FIRMWARE <= 1'b0;
      O_SI_USER <= 1'b0;
      O_PROM_LOW <= 1'b0;
    end else begin
      O_STATUS_B <= `BSC_STAT_RST;
      O_STATUS_B[`BSC_STAT_POS_MSB:`BSC_STAT_POS_LSB] <= pos;
      // Without firmware at power-up the switch has no effect.
      O_SI_FIRMWARE <= O_CFG_VALID && fw_en && !pos[3] && !si_none;
      O_SI_USER <= O_CFG_VALID && fw_en && pos[3] && !si_none;
      O_PROM_LOW <= O_CFG_VALID && fw_en && (low3 < `BSC_L3_PROM_HIGH);
    end
  end

  // ==========================================================
  // Special interrupt edge.
  // A rising halt or init is a special interrupt; firmware handling
  // restarts the response, user handling only signals user code.
  reg si_prev; // Previous synchronised level.
  wire si_rise = si_level && !si_prev;

  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      si_prev <= 1'b0;
      O_USER_SI_EVENT <= 1'b0;
    end else begin
      si_prev <= si_level;
      O_USER_SI_EVENT <= si_rise && O_SI_USER;
    end
  end

  // ==========================================================
  // Checksum engine, shared by user and firmware PROM checks.
  reg ck_start; // One-cycle start toward the engine.
  wire ck_busy;
  wire ck_done;
  wire ck_ok;

  bsc_checksum u_ck (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_start(ck_start | I_FW_CK_START),
    .i_valid(I_CK_VALID),
    .i_last(I_CK_LAST),
    .i_word(I_CK_WORD),
    .o_busy(ck_busy),
    .o_done(ck_done),
    .o_ok(ck_ok),
    .o_sum()
  );

  // ==========================================================
  // Startup sequencer.
  reg [7:0] state; // Current state.
  reg [7:0] next_state; // Next state.
  reg next_ck_start; // Next engine start.

  // Where a position goes once its tests are over.
  function [7:0] after_tests;
    input [2:0] l3;
    begin
      case (l3)
        `BSC_L3_CSUM_APP: after_tests = S_CSUM;
        `BSC_L3_TAPE: after_tests = S_TAPE;
        `BSC_L3_TEST_WAIT: after_tests = S_WAIT;
        `BSC_L3_WAIT: after_tests = S_WAIT;
        `BSC_L3_MONITOR: after_tests = S_MON;
        `BSC_L3_LOOP: after_tests = S_LOOP;
        default: after_tests = S_APP;
      endcase
    end
  endfunction

  // Next-state logic.
  always @* begin
    next_state = state;
    next_ck_start = 1'b0;
    case (state)
      S_SAMPLE: begin
        if (O_CFG_VALID) begin
          if (!fw_en) begin
            next_state = S_MON;
          end else if (pos_tests) begin
            next_state = S_TEST;
          end else begin
            next_state = after_tests(low3);
          end
        end
      end
      S_TEST: begin
        // Failure drops to the monitor unless looping.
        if (I_SELFTEST_DONE) begin
          if (low3 == `BSC_L3_LOOP) begin
            next_state = S_LOOP;
          end else if (!I_SELFTEST_PASS) begin
            next_state = S_MON;
          end else begin
            next_state = after_tests(low3);
            next_ck_start = (low3 == `BSC_L3_CSUM_APP);
          end
        end
      end
      S_CSUM: begin
        if (ck_done) begin
          next_state = ck_ok ? S_APP : S_MON;
        end
      end
      S_LOOP: begin
        // Immediately rerun; the loop never boots.
        next_state = S_TEST;
      end
      S_APP, S_TAPE, S_MON, S_WAIT: begin
        next_state = state;
      end
      default: begin
        next_state = S_SAMPLE;
      end
    endcase
    // Firmware-handled special interrupt replays the response.
    if (si_rise && O_SI_FIRMWARE) begin
      next_state = S_SAMPLE;
      next_ck_start = 1'b0;
    end
  end

  // State and engine start registers.
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state <= S_SAMPLE;
      ck_start <= 1'b0;
    end else begin
      state <= next_state;
      ck_start <= next_ck_start;
    end
  end

  // ==========================================================
  // Sequencer outputs and command capture.
  // Waiting positions idle here and strobe out each arbiter write; standalone
  // boards would never get a command, which is the user's to avoid.
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_SELFTEST_RUN <= 1'b0;
      O_SELFTEST_FAIL <= 1'b0;
      O_CK_RUN <= 1'b0;
      O_CK_DONE <= 1'b0;
      O_CK_OK <= 1'b0;
      O_START_USER_APP <= 1'b0;
      O_TAPE_BOOT <= 1'b0;
      O_ENTER_MONITOR <= 1'b0;
      O_WAIT_COMMAND <= 1'b0;
      O_CMD_STROBE <= 1'b0;
      O_CMD_VALUE <= {`BSC_WORD_W{1'b0}};
    end else begin
      O_SELFTEST_RUN <= (next_state == S_TEST);
      O_CK_RUN <= ck_busy;
      O_START_USER_APP <= (next_state == S_APP);
      O_TAPE_BOOT <= (next_state == S_TAPE);
      O_ENTER_MONITOR <= (next_state == S_MON);
      O_WAIT_COMMAND <= (next_state == S_WAIT);
      O_CMD_STROBE <= 1'b0;
      if (state == S_TEST && I_SELFTEST_DONE) begin
        O_SELFTEST_FAIL <= !I_SELFTEST_PASS;
      end
      if (ck_done) begin
        O_CK_DONE <= 1'b1;
        O_CK_OK <= ck_ok;
      end
      if (state == S_WAIT && I_CMD_WR) begin
        O_CMD_STROBE <= 1'b1;
        O_CMD_VALUE <= I_CMD_DATA;
      end
    end
  end

endmodule // bsc_top

/* File: tb/bsc_arb_model.sv */
// Behavioural host bus arbiter that faces the boot switch decoder.
`timescale 1ns/1ns
module bsc_arb_model (
  // Clock.
  input wire i_clk,
  // Requests from the bench.
  input wire i_acc,
  input wire [21:0] i_addr,
  input wire i_halt,
  input wire [15:0] i_cmd,
  input wire [3:0] i_delay,
  // Board state seen by the arbiter.
  input wire i_wait_cmd,
  // Host bus pins.
  output reg o_addr_valid,
  output reg [21:0] o_addr,
  output reg o_halt,
  output reg o_init,
  output reg [15:0] o_cmd_data,
  output reg o_cmd_wr
);
  reg [3:0] cnt;  // Cycles waited since the board began to wait.
  reg sent;  // Set once the single command of this wait has gone out.

  // ==========================
  // Power-up values of the bus pins.
  initial begin
    {o_addr_valid, o_addr, o_halt, o_init, o_cmd_data, o_cmd_wr, cnt, sent} = 0;
  end

  // ==========================
  // Default master: it owns halt, init and the command writes.
  // It acts 10 ns after the edge, after the bench's own updates, so the two never race.
  // Released address and command data lines show a changing pattern, so a stale value never matches by luck.
  always @(posedge i_clk) begin
    #10;
    // A random command bit picks the line that carries the interrupt, so both are used.
    o_halt = i_halt & ~i_cmd[0];
    o_init = i_halt & i_cmd[0];
    o_addr_valid = i_acc;
    o_addr = i_acc ? i_addr : ~o_addr;
    // One command per wait, after a bench-chosen delay (prompt or slow).
    o_cmd_wr = (i_wait_cmd === 1'b1) && !sent && (cnt == i_delay);
    o_cmd_data = o_cmd_wr ? i_cmd : ~o_cmd_data;
    if (i_wait_cmd !== 1'b1) begin
      cnt = 4'h0;
      sent = 1'b0;
    end else if (!sent) begin
      sent = o_cmd_wr;
      cnt = cnt + 4'h1;
    end
  end
endmodule  // bsc_arb_model

/* File: tb/bsc_top_chk.sv */
// Assertion checker for the boot switch decoder ports.
`timescale 1ns/1ns
module bsc_top_chk (
  // Clock and reset.
  input wire I_CLK,
  input wire I_RST_N,
  // Inputs that cause responses.
  input wire I_CMD_WR,
  input wire [15:0] I_CMD_DATA,
  input wire I_SELFTEST_DONE,
  input wire I_SELFTEST_PASS,
  // Decoded configuration.
  input wire [15:0] O_STATUS_B,
  input wire O_CFG_VALID,
  input wire O_SI_FIRMWARE,
  input wire O_SI_USER,
  input wire O_PROM_LOW,
  input wire O_BUS_ENABLE,
  input wire [1:0] O_BUS_SIZE,
  input wire [21:0] O_BASE_ADDR,
  input wire O_BUS_SELECT,
  // Startup sequence.
  input wire O_SELFTEST_RUN,
  input wire O_START_USER_APP,
  input wire O_TAPE_BOOT,
  input wire O_ENTER_MONITOR,
  input wire O_WAIT_COMMAND,
  input wire O_CMD_STROBE,
  input wire [15:0] O_CMD_VALUE
);
  // ==========================
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  stat_field_a: assert property (O_STATUS_B[15:8] == 8'h00 && O_STATUS_B[3:0] == 4'h0)
    else $error("status bits outside the position field are set");
  si_user_a: assert property (O_SI_USER |-> O_STATUS_B[7] && O_STATUS_B[6:4] != 3'h7)
    else $error("user interrupt handling in a wrong position");
  si_firm_a: assert property (O_SI_FIRMWARE |-> !O_STATUS_B[7] && O_STATUS_B[6:4] != 3'h7 && !O_SI_USER)
    else $error("firmware interrupt handling in a wrong position");
  prom_map_a: assert property ((O_SI_FIRMWARE || O_SI_USER) |-> O_PROM_LOW == (O_STATUS_B[6:4] < 3'h3))
    else $error("prom mapping disagrees with position");
  action_one_a: assert property ($onehot0({O_START_USER_APP, O_TAPE_BOOT, O_ENTER_MONITOR, O_WAIT_COMMAND}))
    else $error("more than one startup action");
  monitor_idle_a: assert property (O_ENTER_MONITOR |-> !O_SELFTEST_RUN)
    else $error("selftest running inside the monitor");
  bus_off_a: assert property (!O_BUS_ENABLE |-> !O_BUS_SELECT)
    else $error("select while bus interface disabled");
  cmd_take_a: assert property (I_CMD_WR && O_WAIT_COMMAND |=> O_CMD_STROBE && O_CMD_VALUE == $past(I_CMD_DATA))
    else $error("command not taken while waiting");
  test_app_a: assert property (O_SELFTEST_RUN && I_SELFTEST_DONE && I_SELFTEST_PASS && O_STATUS_B[6:4] == 3'h1
    |=> !O_SELFTEST_RUN && O_START_USER_APP)
    else $error("passed selftest did not start the application");
  test_tape_a: assert property (O_SELFTEST_RUN && I_SELFTEST_DONE && I_SELFTEST_PASS && O_STATUS_B[6:4] == 3'h3
    |=> O_TAPE_BOOT)
    else $error("passed selftest did not start the tape bootstrap");
  cfg_hold_a: assert property (O_CFG_VALID && $past(O_CFG_VALID) |-> $stable(O_BASE_ADDR) && $stable(O_BUS_SIZE))
    else $error("captured bus configuration changed");
endmodule  // bsc_top_chk

bind bsc_top bsc_top_chk i_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CMD_WR(I_CMD_WR), .I_CMD_DATA(I_CMD_DATA),
  .I_SELFTEST_DONE(I_SELFTEST_DONE), .I_SELFTEST_PASS(I_SELFTEST_PASS), .O_STATUS_B(O_STATUS_B),
  .O_CFG_VALID(O_CFG_VALID), .O_SI_FIRMWARE(O_SI_FIRMWARE), .O_SI_USER(O_SI_USER), .O_PROM_LOW(O_PROM_LOW),
  .O_BUS_ENABLE(O_BUS_ENABLE), .O_BUS_SIZE(O_BUS_SIZE), .O_BASE_ADDR(O_BASE_ADDR), .O_BUS_SELECT(O_BUS_SELECT),
  .O_SELFTEST_RUN(O_SELFTEST_RUN), .O_START_USER_APP(O_START_USER_APP), .O_TAPE_BOOT(O_TAPE_BOOT),
  .O_ENTER_MONITOR(O_ENTER_MONITOR), .O_WAIT_COMMAND(O_WAIT_COMMAND), .O_CMD_STROBE(O_CMD_STROBE),
  .O_CMD_VALUE(O_CMD_VALUE));

/* File: tb/bsc_top_tb.sv */
// Self-checking bench for the boot switch configuration decoder.
`timescale 1ns/1ns
module bsc_top_tb;
  // ==========================
  // Bench-driven pins and design outputs.
  reg clk, rst_n, fw, bj, st_done, st_pass, ck_start, ck_valid, ck_last, halt, acc;
  reg [3:0] sw, id, dly;
  reg [1:0] sz;
  reg [15:0] ck_word, cmd;
  reg [21:0] addr;
  reg [31:0] junk;
  wire av, b_halt, b_init, cmd_wr, cfg_v, si_fw, si_us, plow, ben, bsel, st_run, st_fail;
  wire ck_run, ck_done, ck_ok, app, tape, mon, wcmd, cstb, usi;
  wire [21:0] b_addr, base;
  wire [15:0] cmd_data, stat, cmd_val;
  wire [1:0] bsz;
  integer n_errors, n_compared, t;

  bsc_top i_bsc_top (.I_CLK(clk), .I_RST_N(rst_n), .I_BOOT_SW(sw), .I_FW_AT_POWERUP(fw), .I_BUS_SIZE_J(sz),
    .I_BASE_JUMPER(bj), .I_ID_SW(id), .I_BUS_HALT(b_halt), .I_BUS_INIT(b_init), .I_BUS_ADDR(b_addr),
    .I_BUS_ADDR_VALID(av), .I_SELFTEST_DONE(st_done), .I_SELFTEST_PASS(st_pass), .I_CMD_WR(cmd_wr),
    .I_CMD_DATA(cmd_data), .I_FW_CK_START(ck_start), .I_CK_VALID(ck_valid), .I_CK_LAST(ck_last),
    .I_CK_WORD(ck_word), .O_STATUS_B(stat), .O_CFG_VALID(cfg_v), .O_SI_FIRMWARE(si_fw), .O_SI_USER(si_us),
    .O_PROM_LOW(plow), .O_BUS_ENABLE(ben), .O_BUS_SIZE(bsz), .O_BASE_ADDR(base), .O_BUS_SELECT(bsel),
    .O_SELFTEST_RUN(st_run), .O_SELFTEST_FAIL(st_fail), .O_CK_RUN(ck_run), .O_CK_DONE(ck_done), .O_CK_OK(ck_ok),
    .O_START_USER_APP(app), .O_TAPE_BOOT(tape), .O_ENTER_MONITOR(mon), .O_WAIT_COMMAND(wcmd),
    .O_CMD_STROBE(cstb), .O_CMD_VALUE(cmd_val), .O_USER_SI_EVENT(usi));

  bsc_arb_model i_bsc_arb_model (.i_clk(clk), .i_acc(acc), .i_addr(addr), .i_halt(halt), .i_cmd(cmd),
    .i_delay(dly), .i_wait_cmd(wcmd), .o_addr_valid(av), .o_addr(b_addr), .o_halt(b_halt), .o_init(b_init),
    .o_cmd_data(cmd_data), .o_cmd_wr(cmd_wr));

  // ==========================
  // Helpers: comparison, verdict and expected values.
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
    end
  endtask

  task finish_test;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // Add with the carry dropped, then rotate left by one.
  function [15:0] rotl(input [15:0] s, input [15:0] w);
    reg [15:0] a;
    begin
      a = s + w;
      rotl = {a[14:0], a[15]};
    end
  endfunction

  function [21:0] base_of(input [3:0] d, input j);
    base_of = (d[3] ? 22'h3ffa00 : 22'h3fe000) + {13'h0, d, 5'h0} + (j ? 22'h0 : 22'h400);
  endfunction

  // Streams back-to-back words, the last one carrying the good or a corrupted sum.
  task feed(input good);
    integer i;
    reg [15:0] s;
    begin
      s = 16'h0000;
      ck_valid = 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
        ck_word = (i == 0) ? 16'hffff : 16'($urandom);
        s = rotl(s, ck_word);
        @(posedge clk); #5;
      end
      ck_last = 1'b1;
      ck_word = good ? s : ~s;
      @(posedge clk); #5;
      {ck_valid, ck_last} = 2'b00;
      repeat (3) @(posedge clk); #5;
      chk(ck_done, 1);
      chk(ck_ok, good);
    end
  endtask

  // ==========================
  // One boot from reset with a given switch and jumper setting.
  task run_test(input [3:0] p, input f, input [1:0] s, input j, input [3:0] d);
    integer k, runs;
    reg [2:0] l3;
    reg [21:0] eb, m, a;
    reg seen, tst, bad;
    begin
      l3 = p[2:0];
      {sw, fw, sz, bj, id, acc, halt} = {p, f, s, j, d, 2'b00};
      cmd = 16'($urandom);
      dly = 4'($urandom);
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      #5 rst_n = 1'b1;
      for (k = 0; k < 20 && cfg_v !== 1'b1; k = k + 1) begin @(posedge clk); #5; end
      chk(cfg_v, 1);
      repeat (2) @(posedge clk); #5;
      chk(stat, {8'h00, p, 4'h0});
      chk(si_fw, f && !p[3] && l3 != 3'h7);
      chk(si_us, f && p[3] && l3 != 3'h7);
      chk(plow, f && l3 < 3'h3);
      eb = base_of(d, j);
      chk(base, eb);
      chk(ben, d >= 4'h2);
      chk(bsz, s);
      // Pins moved after capture must be ignored.
      {sw, id, sz, bj, fw} = 12'($urandom);
      runs = 0;
      for (k = 0; k < 80 && (app | tape | mon | wcmd) !== 1'b1; k = k + 1) begin
        @(posedge clk); #5;
        if (st_run === 1'b1) begin
          runs = runs + 1;
          st_done = 1'b1;
          @(posedge clk); #5 st_done = 1'b0;
          @(posedge clk); #5;
        end
        if (ck_run === 1'b1) feed(1'b1);
      end
      // A failed selftest sends every tested position but the loop to the monitor.
      tst = f && (l3 == 3'h1 || l3 == 3'h2 || l3 == 3'h3 || l3 == 3'h5 || l3 == 3'h7);
      bad = tst && !st_pass && l3 != 3'h7;
      chk(runs != 0, tst);
      chk(app, f && l3 < 3'h3 && !bad);
      chk(tape, f && l3 == 3'h3 && !bad);
      chk(mon, !f || l3 == 3'h4 || bad);
      chk(wcmd, f && (l3 == 3'h5 || l3 == 3'h6) && !bad);
      chk(st_fail, tst && !st_pass);
      if (f && l3 == 3'h7) chk(runs > 1, 1);
      if (wcmd === 1'b1) begin
        for (k = 0; k < 30 && cstb !== 1'b1; k = k + 1) begin @(posedge clk); #5; end
        chk(cstb, 1);
        chk(cmd_val, cmd);
      end
      if (f && l3 == 3'h4) begin
        ck_start = 1'b1;
        @(posedge clk); #5 ck_start = 1'b0;
        for (k = 0; k < 10 && ck_run !== 1'b1; k = k + 1) begin @(posedge clk); #5; end
        feed(1'b0);
      end
      // Address decode: exact, all window bits flipped, and off by one window.
      m = (s == 2'h3) ? 22'h3fffff : (s == 2'h1) ? 22'h03ffff : 22'h00ffff;
      for (k = 0; k < 3; k = k + 1) begin
        a = (eb & m) | (~m & 22'($urandom));
        a = a ^ ((k == 1) ? 22'h1f : (k == 2) ? 22'h20 : 22'h0);
        addr = a;
        acc = 1'b1;
        repeat (5) @(posedge clk); #5;
        chk(bsel, ben && (((a ^ eb) & m & 22'h3fffe0) == 22'h0));
        acc = 1'b0;
        repeat (4) @(posedge clk); #5;
      end
      chk(stat, {8'h00, p, 4'h0});
      // Special interrupt through the bus halt or init line, as the arbiter's cmd[0] picks.
      halt = 1'b1;
      seen = 1'b0;
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge clk); #5;
        if (k == 2) halt = 1'b0;
        if (usi === 1'b1) seen = 1'b1;
      end
      chk(seen, f && p[3] && l3 != 3'h7);
      if (f && p[3] && l3 != 3'h7) chk(app | tape | mon | wcmd, 1);
      $display("test position %0d done, mismatches %0d", p, n_errors);
    end
  endtask

  // ==========================
  // Clock, hang guard and main sequence.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_errors = n_errors + 1;
    finish_test;
  end

  initial begin
    {n_errors, n_compared} = 0;
    {rst_n, fw, bj, st_done, ck_start, ck_valid, ck_last, halt, acc, sw, id, dly, sz, ck_word, cmd, addr} = 0;
    st_pass = 1'b1;  // Selftests pass until the failure corners at the end.
    junk = $urandom(32'ha32d);
    // Wait positions only with the bus enabled, never standalone.
    for (t = 0; t < 16; t = t + 1) run_test(t[3:0], 1'b1, 2'($urandom), 1'($urandom), 4'(2 + $urandom % 14));
    run_test(4'h5, 1'b0, 2'h3, 1'b1, 4'h0);  // Monitor jumper with standalone board.
    run_test(4'($urandom), 1'b0, 2'h2, 1'b0, 4'h1);
    // Failing selftests: the tape position drops to the monitor, the loop position keeps looping.
    st_pass = 1'b0;
    run_test(4'hb, 1'b1, 2'h1, 1'b0, 4'h9);
    run_test(4'hf, 1'b1, 2'h3, 1'b1, 4'h3);
    finish_test;
  end
endmodule  // bsc_top_tb
